// ===== rtl/two_wire_master_pkg.sv
// constants, types and helpers shared by the two-wire master engine
// assumes a single 25 MHz system clock feeding every block
//
// Behaviour
// - acts only as master on a two-line clock and data link, never slave.
// - assumes sole master; no arbitration or arbitration-loss detection.
// - inserts no wait states and never waits on slave clock stretching, only flags it.
// - bus clock selectable at 100 kHz, 400 kHz, 800 kHz or 1 MHz.
// - read transfer fetches one to sixteen bytes in one transaction.
// - write transfer sends one to sixteen bytes in one transaction.
// - read-then-write reads then writes, up to sixteen each, one operation.
// - write-then-read writes then reads, up to sixteen each, one operation.
// - after setup, hardware sequences every bit and byte without firmware.
// - both lines open-drain: pulled low or released, never driven high.
// - low-power clock request is enable registered, so it follows enable one clock cycle later.
package two_wire_master_pkg;

  localparam int CLK_HZ       = 25_000_000;
  localparam int RATE_100K_HZ = 100_000;
  localparam int RATE_400K_HZ = 400_000;
  localparam int RATE_800K_HZ = 800_000;
  localparam int RATE_1M_HZ   = 1_000_000;

  // quarter of a bus period, rounded up so the bus never runs too fast
  localparam int Q_100K = (CLK_HZ + 4 * RATE_100K_HZ - 1) / (4 * RATE_100K_HZ);
  localparam int Q_400K = (CLK_HZ + 4 * RATE_400K_HZ - 1) / (4 * RATE_400K_HZ);
  localparam int Q_800K = (CLK_HZ + 4 * RATE_800K_HZ - 1) / (4 * RATE_800K_HZ);
  localparam int Q_1M   = (CLK_HZ + 4 * RATE_1M_HZ - 1) / (4 * RATE_1M_HZ);

  localparam int BUF_DEPTH   = 16;
  localparam int BYTE_BITS   = 8;
  localparam int ACK_BIT_IDX = 8;

  typedef logic [6:0] qcount_type;
  typedef logic [3:0] idx_type;
  typedef logic [7:0] byte_type;

  typedef enum logic [1:0] {
    XFER_READ,
    XFER_WRITE,
    XFER_RD_WR,
    XFER_WR_RD
  } xfer_kind_type;

  typedef enum logic [1:0] {
    RATE_100K,
    RATE_400K,
    RATE_800K,
    RATE_1M
  } rate_type;

  // lengths are byte count minus one, so 0 means one byte
  typedef struct packed {
    xfer_kind_type kind;
    rate_type      rate;
    logic [6:0]    addr;
    idx_type       rd_len_m1;
    idx_type       wr_len_m1;
  } xfer_req_type;

  function automatic qcount_type quarter_count(input rate_type r);
    case (r)
      RATE_100K: quarter_count = qcount_type'(Q_100K);
      RATE_400K: quarter_count = qcount_type'(Q_400K);
      RATE_800K: quarter_count = qcount_type'(Q_800K);
      default:   quarter_count = qcount_type'(Q_1M);
    endcase
  endfunction

  function automatic logic phase_reads(input xfer_kind_type k,
                                       input logic second);
    case (k)
      XFER_READ:  phase_reads = 1'b1;
      XFER_WRITE: phase_reads = 1'b0;
      XFER_RD_WR: phase_reads = ~second;
      default:    phase_reads = second;
    endcase
  endfunction

endpackage

// ===== rtl/two_flop_sync.sv
// two-stage synchroniser for the two bus line levels
// assumes the inputs are asynchronous pin levels
`timescale 1ns/1ps
module two_flop_sync (
  input  wire logic       mclk_in,
  input  wire logic       rst_n_in,
  input  wire logic [1:0] async_in,
  output logic      [1:0] sync_out
);
  logic [1:0] meta_r;

  // released lines idle high, so reset to the high level
  for (genvar i = 0; i < 2; i++) begin : g_bit
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        meta_r[i]   <= 1'b1;
        sync_out[i] <= 1'b1;
      end else begin
        meta_r[i]   <= async_in[i];
        sync_out[i] <= meta_r[i];
      end
    end
  end
endmodule

// ===== rtl/quarter_tick.sv
// quarter bus period tick generator
// assumes run_in and rate_in come from logic on the same clock
`timescale 1ns/1ps
module quarter_tick
  import two_wire_master_pkg::*;
(
  input  wire logic                         mclk_in,
  input  wire logic                         rst_n_in,
  input  wire logic                         run_in,
  input  wire two_wire_master_pkg::rate_type rate_in,
  output logic                              tick_out
);
  import two_wire_master_pkg::*;

  qcount_type cnt_r;
  qcount_type limit_m1;

  assign limit_m1 = quarter_count(rate_in) - qcount_type'(1);

  // restarts from zero on every run so the first quarter is full length
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_r    <= '0;
      tick_out <= 1'b0;
    end else if (!run_in) begin
      cnt_r    <= '0;
      tick_out <= 1'b0;
    end else if (cnt_r == limit_m1) begin
      cnt_r    <= '0;
      tick_out <= 1'b1;
    end else begin
      cnt_r    <= cnt_r + qcount_type'(1);
      tick_out <= 1'b0;
    end
  end
endmodule

// ===== rtl/two_wire_master.sv
// two-wire bus master transfer engine with byte buffers
// assumes firmware-side ports are on mclk_in; bus pins need pull-ups
`timescale 1ns/1ps
module two_wire_master
  import two_wire_master_pkg::*;
(
  input  wire logic                             mclk_in,
  input  wire logic                             rst_n_in,
  input  wire logic                             enable_in,
  input  wire logic                             start_in,
  input  wire two_wire_master_pkg::xfer_req_type req_in,
  input  wire logic                             wbuf_we_in,
  input  wire two_wire_master_pkg::idx_type      wbuf_addr_in,
  input  wire two_wire_master_pkg::byte_type     wbuf_data_in,
  input  wire two_wire_master_pkg::idx_type      rbuf_addr_in,
  output two_wire_master_pkg::byte_type          rbuf_data_out,
  output logic                                  busy_out,
  output logic                                  done_out,
  output logic                                  nack_err_out,
  output logic                                  stretch_seen_out,
  output logic                                  clk_req_out,
  input  wire logic                             scl_in,
  output logic                                  scl_out,
  output logic                                  scl_oe_out,
  input  wire logic                             sda_in,
  output logic                                  sda_out,
  output logic                                  sda_oe_out
);
  import two_wire_master_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_START,
    ST_BIT,
    ST_STOP
  } state_type;

  state_type    state_r,    state_nxt;
  xfer_req_type req_r,      req_nxt;
  logic [1:0]   q_r,        q_nxt;
  logic [3:0]   bit_r,      bit_nxt;
  idx_type      cnt_r,      cnt_nxt;
  byte_type     sr_r,       sr_nxt;
  logic         phase_r,    phase_nxt;
  logic         is_addr_r,  is_addr_nxt;
  logic         scl_low_r,  scl_low_nxt;
  logic         sda_low_r,  sda_low_nxt;
  logic         busy_r,     busy_nxt;
  logic         done_r,     done_nxt;
  logic         err_r,      err_nxt;
  logic         stretch_r,  stretch_nxt;
  logic         clk_req_r;
  byte_type     rbuf_data_r;

  byte_type     wbuf [BUF_DEPTH];
  byte_type     rbuf [BUF_DEPTH];

  logic [1:0]   line_s;
  logic         tick;
  logic         scl_s;
  logic         sda_s;
  logic         phase_rd;
  logic         two_phase;
  idx_type      len_m1;
  logic         tx_byte;
  logic         last_byte;
  logic         ack_bit;
  logic         start_ok;
  logic         rbuf_we;

  two_flop_sync u_sync (
    .mclk_in  (mclk_in),
    .rst_n_in (rst_n_in),
    .async_in ({scl_in, sda_in}),
    .sync_out (line_s)
  );

  quarter_tick u_tick (
    .mclk_in  (mclk_in),
    .rst_n_in (rst_n_in),
    .run_in   (busy_r),
    .rate_in  (req_r.rate),
    .tick_out (tick)
  );

  assign scl_s     = line_s[1];
  assign sda_s     = line_s[0];
  assign phase_rd  = phase_reads(req_r.kind, phase_r);
  assign two_phase = (req_r.kind == XFER_RD_WR) || (req_r.kind == XFER_WR_RD);
  assign len_m1    = phase_rd ? req_r.rd_len_m1 : req_r.wr_len_m1;
  assign tx_byte   = is_addr_r || !phase_rd;
  assign last_byte = (cnt_r == len_m1);
  assign ack_bit   = (bit_r == 4'(ACK_BIT_IDX));
  // only one master exists, so a start never waits on a busy bus
  assign start_ok  = start_in && enable_in && !busy_r;
  assign rbuf_we   = tick && (state_r == ST_BIT) && (q_r == 2'h3) &&
                     ack_bit && !tx_byte;

  // each bit spans four quarters: set data, release clock, sample, pull low
  always_comb begin
    state_nxt   = state_r;
    req_nxt     = req_r;
    q_nxt       = q_r;
    bit_nxt     = bit_r;
    cnt_nxt     = cnt_r;
    sr_nxt      = sr_r;
    phase_nxt   = phase_r;
    is_addr_nxt = is_addr_r;
    scl_low_nxt = scl_low_r;
    sda_low_nxt = sda_low_r;
    busy_nxt    = busy_r;
    done_nxt    = 1'b0;
    err_nxt     = err_r;
    stretch_nxt = stretch_r;
    if (!enable_in) begin
      // disabling abandons the transfer and lets both lines float
      state_nxt   = ST_IDLE;
      scl_low_nxt = 1'b0;
      sda_low_nxt = 1'b0;
      busy_nxt    = 1'b0;
    end else if (state_r == ST_IDLE) begin
      scl_low_nxt = 1'b0;
      sda_low_nxt = 1'b0;
      if (start_ok) begin
        req_nxt     = req_in;
        state_nxt   = ST_START;
        q_nxt       = 2'h0;
        phase_nxt   = 1'b0;
        err_nxt     = 1'b0;
        stretch_nxt = 1'b0;
        busy_nxt    = 1'b1;
      end
    end else if (tick) begin
      q_nxt = q_r + 2'h1;
      case (state_r)
        ST_START: begin
          case (q_r)
            2'h0: begin
              scl_low_nxt = 1'b1;
              sda_low_nxt = 1'b0;
            end
            2'h1: scl_low_nxt = 1'b0;
            2'h2: sda_low_nxt = 1'b1;
            default: begin
              scl_low_nxt = 1'b1;
              sr_nxt      = {req_r.addr, phase_rd};
              bit_nxt     = 4'h0;
              is_addr_nxt = 1'b1;
              state_nxt   = ST_BIT;
            end
          endcase
        end
        ST_BIT: begin
          case (q_r)
            2'h0: begin
              if (!ack_bit)
                sda_low_nxt = tx_byte && !sr_r[7];
              else
                sda_low_nxt = !tx_byte && !last_byte;
            end
            2'h1: scl_low_nxt = 1'b0;
            2'h2: begin
              // a slave holding the clock low is only noted, never waited on
              if (!scl_s)
                stretch_nxt = 1'b1;
              if (!ack_bit && !tx_byte)
                sr_nxt = {sr_r[6:0], sda_s};
              if (ack_bit && tx_byte && sda_s)
                err_nxt = 1'b1;
            end
            default: begin
              scl_low_nxt = 1'b1;
              if (!ack_bit) begin
                bit_nxt = bit_r + 4'h1;
                if (tx_byte)
                  sr_nxt = {sr_r[6:0], 1'b0};
              end else if (tx_byte && err_r) begin
                state_nxt = ST_STOP;
              end else if (is_addr_r) begin
                is_addr_nxt = 1'b0;
                cnt_nxt     = 4'h0;
                bit_nxt     = 4'h0;
                sr_nxt      = wbuf[0];
              end else if (last_byte) begin
                if (two_phase && !phase_r) begin
                  phase_nxt = 1'b1;
                  state_nxt = ST_START;
                end else begin
                  state_nxt = ST_STOP;
                end
              end else begin
                cnt_nxt = cnt_r + 4'h1;
                bit_nxt = 4'h0;
                sr_nxt  = wbuf[cnt_r + 4'h1];
              end
            end
          endcase
        end
        ST_STOP: begin
          case (q_r)
            2'h0: begin
              scl_low_nxt = 1'b1;
              sda_low_nxt = 1'b1;
            end
            2'h1: scl_low_nxt = 1'b0;
            2'h2: sda_low_nxt = 1'b0;
            default: begin
              state_nxt = ST_IDLE;
              busy_nxt  = 1'b0;
              done_nxt  = 1'b1;
            end
          endcase
        end
        default: state_nxt = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r   <= ST_IDLE;
      req_r     <= '0;
      q_r       <= 2'h0;
      bit_r     <= 4'h0;
      cnt_r     <= 4'h0;
      sr_r      <= 8'h00;
      phase_r   <= 1'b0;
      is_addr_r <= 1'b0;
      scl_low_r <= 1'b0;
      sda_low_r <= 1'b0;
      busy_r    <= 1'b0;
      done_r    <= 1'b0;
      err_r     <= 1'b0;
      stretch_r <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      req_r     <= req_nxt;
      q_r       <= q_nxt;
      bit_r     <= bit_nxt;
      cnt_r     <= cnt_nxt;
      sr_r      <= sr_nxt;
      phase_r   <= phase_nxt;
      is_addr_r <= is_addr_nxt;
      scl_low_r <= scl_low_nxt;
      sda_low_r <= sda_low_nxt;
      busy_r    <= busy_nxt;
      done_r    <= done_nxt;
      err_r     <= err_nxt;
      stretch_r <= stretch_nxt;
    end
  end

  // firmware writes are refused mid-transfer so bytes cannot change under us
  always_ff @(posedge mclk_in) begin
    if (wbuf_we_in && !busy_r)
      wbuf[wbuf_addr_in] <= wbuf_data_in;
    if (rbuf_we)
      rbuf[cnt_r] <= sr_r;
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      clk_req_r   <= 1'b0;
      rbuf_data_r <= 8'h00;
    end else begin
      clk_req_r   <= enable_in;
      rbuf_data_r <= rbuf[rbuf_addr_in];
    end
  end

  // lines are only ever pulled low; pull-ups make the high level
  assign scl_out          = 1'b0;
  assign sda_out          = 1'b0;
  assign scl_oe_out       = scl_low_r;
  assign sda_oe_out       = sda_low_r;
  assign busy_out         = busy_r;
  assign done_out         = done_r;
  assign nack_err_out     = err_r;
  assign stretch_seen_out = stretch_r;
  assign clk_req_out      = clk_req_r;
  assign rbuf_data_out    = rbuf_data_r;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_start_edge;
    (state_r == ST_START) && tick && (q_r == 2'h2);
  endsequence

  sequence s_start_lines;
    sda_oe_out && !scl_oe_out;
  endsequence

  AST_START_COND: assert property (
    s_start_edge |=> s_start_lines)
    else $error("start condition not formed");

  AST_CLKREQ: assert property (
    !enable_in |=> !clk_req_out)
    else $error("clock request while disabled");

  AST_NO_HIGH_DRIVE: assert property (
    !scl_out && !sda_out)
    else $error("line driven high");

  AST_IDLE_RELEASE: assert property (
    !busy_out && $past(!busy_out) |-> !scl_oe_out && !sda_oe_out)
    else $error("line pulled while idle");

  AST_NACK_STOP: assert property (
    disable iff (!rst_n_in || !enable_in)
    $rose(nack_err_out) |-> ##[1:400] done_out)
    else $error("nack not followed by completion");

  AST_SCL_HIGH_BOUND: assert property (
    disable iff (!rst_n_in || !enable_in)
    busy_out && $fell(scl_oe_out) |-> ##[1:200] scl_oe_out || !busy_out)
    else $error("clock held released too long");

  AST_RATE_1M: assert property (
    disable iff (!rst_n_in || !enable_in)
    tick && (req_r.rate == RATE_1M) && busy_r &&
    !((state_r == ST_STOP) && (q_r == 2'h3)) |=> (!tick)[*6] ##1 tick)
    else $error("1 MHz quarter length wrong");

  AST_RATE_800K: assert property (
    disable iff (!rst_n_in || !enable_in)
    tick && (req_r.rate == RATE_800K) && busy_r &&
    !((state_r == ST_STOP) && (q_r == 2'h3)) |=> (!tick)[*7] ##1 tick)
    else $error("800 kHz quarter length wrong");

  AST_READ_ACK: assert property (
    (state_r == ST_BIT) && (q_r == 2'h1) && ack_bit && !tx_byte |->
    sda_oe_out == !last_byte)
    else $error("read ack level wrong");

  AST_HW_SEQ: assert property (
    disable iff (!rst_n_in || !enable_in)
    start_ok |=> busy_out ##1 busy_out)
    else $error("accepted start did not run");

endmodule

// ===== verification/two_wire_slave_model.sv
// behavioural slave with a 16-byte memory on the two-wire bus
// assumes the bench resolves both open-drain lines with pull-ups
`timescale 1ns/1ps
module two_wire_slave_model #(
  parameter logic [6:0] DEV_ADDR = 7'h2A
) (
  input  wire logic scl_in,
  input  wire logic sda_in,
  input  wire logic nack_data_in,
  output logic      sda_pull_out
);
  logic [7:0] mem [16];
  logic [7:0] sh;
  logic       act, rd, adr, ok, last;
  int         bc, ptr, stops;
  initial begin
    sda_pull_out = 1'b0;
    act          = 1'b0;
    stops        = 0;
  end
  // start or repeated start rewinds the pointer
  always @(negedge sda_in) if (scl_in) begin
    act  = 1'b1;
    adr  = 1'b1;
    last = 1'b0;
    bc   = 0;
    ptr  = 0;
  end
  // time zero guard: pull-up settling is not a stop
  always @(posedge sda_in) if (scl_in && $time > 0) begin
    stops++;
    act = 1'b0;
  end
  // one shifter serves both ways: sh[7] is always the next bit out
  always @(posedge scl_in) if (act) begin
    if (bc < 8) sh = {sh[6:0], sda_in};
    else if (rd && !adr) last = sda_in;
    bc++;
  end
  // never stretches: every bit is ready before the clock rises
  always @(negedge scl_in) if (act) begin
    sda_pull_out = 1'b0;
    if (bc == 8 && (adr || !rd)) begin
      ok = adr ? (sh[7:1] == DEV_ADDR) : !nack_data_in;
      if (adr) rd = sh[0];
      else begin
        mem[ptr] = sh;
        ptr++;
      end
      sda_pull_out = ok;
    end else if (bc == 9) begin
      bc  = 0;
      adr = 1'b0;
      if (!ok || last) act = 1'b0;
      else if (rd) begin
        sh = mem[ptr];
        ptr++;
      end
    end
    if (act && rd && !adr && bc < 8) sda_pull_out = !sh[7];
  end
endmodule

// ===== verification/tb_top.sv
// self-checking bench for the two-wire master against a slave model
// assumes the master only pulls lines low; the bench adds pull-ups
`timescale 1ns/1ps
module tb_top;
  import two_wire_master_pkg::*;
  localparam logic [6:0] DEV = 7'h2A;
  logic         mclk_in, rst_n_in, enable_in, start_in, wbuf_we_in;
  xfer_req_type req_in;
  idx_type      wbuf_addr_in, rbuf_addr_in;
  byte_type     wbuf_data_in, rbuf_data_out;
  logic         busy_out, done_out, nack_err_out, stretch_seen_out;
  logic         clk_req_out, scl_out, scl_oe_out, sda_out, sda_oe_out;
  logic         scl_w, sda_w, sda_pull, stretch, nack_data, prev_oe, bad_drv;
  byte_type     wb [16];
  byte_type     smem [16];
  byte_type     erb [16];
  int           err_total, comparisons, cyc, cyc_ref, per, cnt, nrd, stp;
  int           q_tab [4] = '{63, 16, 8, 7};

  initial begin
    mclk_in = 1'b0;
    forever #20 mclk_in = ~mclk_in;
  end
  assign scl_w = !(scl_oe_out || stretch);
  assign sda_w = !(sda_oe_out || sda_pull);

  two_wire_master u_two_wire_master (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .enable_in(enable_in),
    .start_in(start_in), .req_in(req_in), .wbuf_we_in(wbuf_we_in),
    .wbuf_addr_in(wbuf_addr_in), .wbuf_data_in(wbuf_data_in),
    .rbuf_addr_in(rbuf_addr_in), .rbuf_data_out(rbuf_data_out),
    .busy_out(busy_out), .done_out(done_out), .nack_err_out(nack_err_out),
    .stretch_seen_out(stretch_seen_out), .clk_req_out(clk_req_out),
    .scl_in(scl_w), .scl_out(scl_out), .scl_oe_out(scl_oe_out),
    .sda_in(sda_w), .sda_out(sda_out), .sda_oe_out(sda_oe_out));
  two_wire_slave_model #(.DEV_ADDR(DEV)) u_two_wire_slave_model (
    .scl_in(scl_w), .sda_in(sda_w), .nack_data_in(nack_data),
    .sda_pull_out(sda_pull));

  // bit period: cycles between rising clock-pull enables
  always @(posedge mclk_in) begin
    prev_oe <= scl_oe_out;
    cnt     <= cnt + 1;
    if (scl_oe_out && !prev_oe) begin
      per <= cnt + 1;
      cnt <= 0;
    end
    if (scl_out !== 1'b0 || sda_out !== 1'b0) bad_drv <= 1'b1;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic rd_exp(input idx_type rl);
    for (int i = 0; i <= rl; i++) erb[i] = smem[i];
    nrd = rl + 1;
  endtask

  task automatic run(input string nm, input logic [1:0] k,
                     input rate_type rt, input logic [6:0] ad,
                     input idx_type rl, input idx_type wl);
    logic ok;
    nrd = 0;
    for (int i = 0; i < 16; i++) begin
      wb[i]        = byte_type'($urandom);
      wbuf_we_in   = 1'b1;
      wbuf_addr_in = idx_type'(i);
      wbuf_data_in = wb[i];
      @(negedge mclk_in);
    end
    wbuf_we_in = 1'b0;
    req_in     = '{xfer_kind_type'(k), rt, ad, rl, wl};
    start_in   = 1'b1;
    @(negedge mclk_in);
    start_in = 1'b0;
    chk(busy_out, 1'b1);
    cyc = 0;
    // longest single transfer is under 10000 cycles
    while (done_out !== 1'b1 && cyc < 12000) begin
      @(negedge mclk_in);
      cyc++;
    end
    chk({done_out, busy_out}, 2'b10);
    ok = (ad == DEV);
    if (ok && k == 2'd2) rd_exp(rl);
    if (ok && k != 2'd0) begin
      for (int i = 0; i <= wl; i++) begin
        smem[i] = wb[i];
        if (nack_data) break;
      end
      ok = !nack_data;
    end
    if (ok && (k == 2'd0 || k == 2'd3)) rd_exp(rl);
    chk(nack_err_out, !ok);
    chk(stretch_seen_out, stretch);
    if (!stretch) begin
      stp++;
      chk(16'(u_two_wire_slave_model.stops), 16'(stp));
    end
    for (int i = 0; i < nrd; i++) begin
      rbuf_addr_in = idx_type'(i);
      @(negedge mclk_in);
      chk(rbuf_data_out, erb[i]);
    end
    for (int i = 0; i < 16; i++)
      chk(u_two_wire_slave_model.mem[i], smem[i]);
    $display("test %s done", nm);
  endtask

  initial begin
    {rst_n_in, start_in, wbuf_we_in, stretch, nack_data} = '0;
    {bad_drv, prev_oe, wbuf_addr_in, wbuf_data_in, rbuf_addr_in} = '0;
    {cnt, per, err_total, comparisons, stp} = '0;
    enable_in = 1'b1;
    req_in    = '0;
    void'($urandom(90776));
    for (int i = 0; i < 16; i++) begin
      smem[i]                       = byte_type'($urandom);
      u_two_wire_slave_model.mem[i] = smem[i];
    end
    repeat (16) @(negedge mclk_in);
    rst_n_in = 1'b1;
    @(negedge mclk_in);
    chk(clk_req_out, 1'b1);
    for (int r = 0; r < 4; r++) begin
      run("rate", 2'd1, rate_type'(r), DEV, 4'h0, 4'h0);
      chk(16'(per), 16'(4 * q_tab[r]));
    end
    run("nack_addr", 2'd3, RATE_1M, DEV ^ 7'h01, 4'h3, 4'h3);
    cyc_ref   = cyc;
    nack_data = 1'b1;
    run("nack_data", 2'd1, RATE_1M, DEV, 4'h0, 4'h5);
    nack_data = 1'b0;
    // clock held low all through: no stop reaches the slave
    stretch = 1'b1;
    run("stretch", 2'd3, RATE_1M, DEV ^ 7'h01, 4'h3, 4'h3);
    stretch = 1'b0;
    chk(16'(cyc), 16'(cyc_ref));
    chk(stretch_seen_out, 1'b1);
    run("rd1", 2'd0, RATE_1M, DEV, 4'h0, 4'h0);
    run("wr16", 2'd1, RATE_1M, DEV, 4'h0, 4'hF);
    run("rdwr", 2'd2, RATE_800K, DEV, 4'hF, 4'hF);
    run("wrrd", 2'd3, RATE_1M, DEV, 4'hF, 4'hF);
    for (int t = 0; t < 6; t++)
      run("rand", 2'($urandom), rate_type'(2 + $urandom % 2), DEV,
          idx_type'($urandom), idx_type'($urandom));
    // abort inside the address byte, while the slave only listens
    req_in   = '{XFER_WRITE, RATE_100K, DEV, 4'h0, 4'h0};
    start_in = 1'b1;
    @(negedge mclk_in);
    start_in = 1'b0;
    repeat (1000) @(negedge mclk_in);
    enable_in = 1'b0;
    start_in  = 1'b1;
    @(negedge mclk_in);
    chk(clk_req_out, 1'b0);
    chk({busy_out, done_out, scl_oe_out, sda_oe_out}, 4'h0);
    @(negedge mclk_in);
    chk(busy_out, 1'b0);
    start_in  = 1'b0;
    enable_in = 1'b1;
    stp       = u_two_wire_slave_model.stops;
    @(negedge mclk_in);
    chk(clk_req_out, 1'b1);
    $display("test abort done");
    run("after_abort", 2'd3, RATE_1M, DEV, 4'h2, 4'h1);
    chk(bad_drv, 1'b0);
    tally_and_finish();
  end

  initial begin
    // every test at its worst length adds up to about 95000 cycles
    #(98000 * 40);
    err_total++;
    tally_and_finish();
  end
endmodule
